// >>> hw/asram_consts.svh
`ifndef ASRAM_CONSTS_SVH
`define ASRAM_CONSTS_SVH
`define ASRAM_CLK_PERIOD_NS 100
`define ASRAM_READ_CYCLE_MIN_NS 45
`define ASRAM_ADDRESS_ACCESS_MAX_NS 45
`define ASRAM_OE_RELEASE_MAX_NS 15
`define ASRAM_SEL_RELEASE_MAX_NS 20
`define ASRAM_ADDR_TO_END_MIN_NS 40
`define ASRAM_WRITE_DATA_SETUP_NS 25
`define ASRAM_WRITE_CYCLE_MIN_NS 45
`define ASRAM_CYC(ns) ((((ns) + `ASRAM_CLK_PERIOD_NS - 1) / \
  `ASRAM_CLK_PERIOD_NS) < 1 ? 1 : (((ns) + `ASRAM_CLK_PERIOD_NS - 1) / \
  `ASRAM_CLK_PERIOD_NS))
`define ASRAM_READ_CYCLES `ASRAM_CYC(`ASRAM_ADDRESS_ACCESS_MAX_NS)
`define ASRAM_WRITE_CYCLES `ASRAM_CYC(`ASRAM_ADDR_TO_END_MIN_NS)
`define ASRAM_RELEASE_CYCLES `ASRAM_CYC(`ASRAM_SEL_RELEASE_MAX_NS)
`define ASRAM_ADDR_W 20
`define ASRAM_DATA_W 16
`endif

// >>> hw/asram_pkg.sv
package asram_pkg;
  typedef struct packed {
    logic        write;
    logic [1:0]  lane_n;
    logic [19:0] addr;
    logic [15:0] wdata;
  } asram_req_type;

  typedef enum logic [2:0] {
    ASRAM_IDLE  = 3'h0,
    ASRAM_SETUP = 3'h1,
    ASRAM_READ  = 3'h3,
    ASRAM_WRITE = 3'h2,
    ASRAM_TURN  = 3'h6
  } asram_state_type;
endpackage : asram_pkg

// >>> hw/asram_ctrl.sv
`timescale 1ns/100ps
`include "asram_consts.svh"
module asram_ctrl (
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        srst_in,
  // user request
  input  wire logic        req_valid_in,
  input  asram_pkg::asram_req_type req_in,
  output logic             req_ready_out,
  output logic             rd_valid_out,
  output logic [15:0]      rd_data_out,
  // memory pins
  output logic [19:0]      mem_addr_out,
  output logic             select_low_active_out,
  output logic             select_high_active_out,
  output logic             mem_we_n_out,
  output logic             mem_oe_n_out,
  output logic             upper_lane_enable_n_out,
  output logic             lower_lane_enable_n_out,
  input  wire logic [15:0] mem_dq_in,
  output logic [15:0]      mem_dq_out,
  output logic [15:0]      mem_dq_oe_out
);

  // ****************************************
  // state
  // ****************************************
  localparam int RD_CYC  = `ASRAM_READ_CYCLES;
  localparam int WR_CYC  = `ASRAM_WRITE_CYCLES;
  localparam int REL_CYC = `ASRAM_RELEASE_CYCLES;

  asram_pkg::asram_state_type state_q;
  asram_pkg::asram_req_type   req_q;
  logic [3:0]                 cnt_q;
  logic [15:0]                dq_s1_q;
  logic [15:0]                dq_s2_q;
  logic                       cnt_done;

  assign cnt_done      = (cnt_q == 4'h0);
  assign req_ready_out = (state_q == asram_pkg::ASRAM_IDLE);

  // ****************************************
  // pin input synchroniser
  // ****************************************
  always_ff @(posedge core_clk_in) begin
    dq_s1_q <= mem_dq_in;
    dq_s2_q <= dq_s1_q;
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      state_q <= asram_pkg::ASRAM_IDLE;
      cnt_q   <= 4'h0;
    end else begin
      unique case (state_q)
        asram_pkg::ASRAM_IDLE: begin
          if (req_valid_in) begin
            state_q <= asram_pkg::ASRAM_SETUP;
          end
        end
        asram_pkg::ASRAM_SETUP: begin
          if (req_q.write) begin
            state_q <= asram_pkg::ASRAM_WRITE;
            cnt_q   <= 4'(WR_CYC - 1);
          end else begin
            state_q <= asram_pkg::ASRAM_READ;
            cnt_q   <= 4'(RD_CYC + 1);
          end
        end
        asram_pkg::ASRAM_READ, asram_pkg::ASRAM_WRITE: begin
          if (cnt_done) begin
            state_q <= asram_pkg::ASRAM_TURN;
            cnt_q   <= 4'(REL_CYC - 1);
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        asram_pkg::ASRAM_TURN: begin
          if (cnt_done) begin
            state_q <= asram_pkg::ASRAM_IDLE;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default: begin
          state_q <= asram_pkg::ASRAM_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // request capture
  // ****************************************
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      req_q <= '0;
    end else if (req_ready_out && req_valid_in) begin
      req_q <= req_in;
    end
  end

  // ****************************************
  // pin drivers
  // ****************************************
  logic active;
  assign active = (state_q == asram_pkg::ASRAM_READ) ||
                  (state_q == asram_pkg::ASRAM_WRITE);

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      mem_addr_out            <= 20'h00000;
      select_low_active_out   <= 1'b1;
      select_high_active_out  <= 1'b0;
      mem_we_n_out            <= 1'b1;
      mem_oe_n_out            <= 1'b1;
      upper_lane_enable_n_out <= 1'b1;
      lower_lane_enable_n_out <= 1'b1;
      mem_dq_out              <= 16'h0000;
      mem_dq_oe_out           <= 16'h0000;
    end else begin
      if (state_q == asram_pkg::ASRAM_SETUP) begin
        mem_addr_out <= req_q.addr;
        mem_dq_out   <= req_q.wdata;
      end
      // selects, lanes, strobes asserted together, dropped together
      if (state_q == asram_pkg::ASRAM_SETUP) begin
        select_low_active_out   <= 1'b0;
        select_high_active_out  <= 1'b1;
        upper_lane_enable_n_out <= req_q.lane_n[1];
        lower_lane_enable_n_out <= req_q.lane_n[0];
        mem_we_n_out            <= ~req_q.write;
        mem_oe_n_out            <= req_q.write;
        mem_dq_oe_out <= req_q.write ?
          {{8{~req_q.lane_n[1]}}, {8{~req_q.lane_n[0]}}} : 16'h0000;
      end else if (active && cnt_done) begin
        select_low_active_out   <= 1'b1;
        select_high_active_out  <= 1'b0;
        upper_lane_enable_n_out <= 1'b1;
        lower_lane_enable_n_out <= 1'b1;
        mem_we_n_out            <= 1'b1;
        mem_oe_n_out            <= 1'b1;
        // data held through the ending edge: enables drop one cycle later, in TURN
        mem_dq_oe_out <= mem_dq_oe_out;
      end else if (state_q == asram_pkg::ASRAM_TURN) begin
        mem_dq_oe_out <= 16'h0000;
      end
    end
  end

  // ****************************************
  // read data return
  // ****************************************
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      rd_valid_out <= 1'b0;
      rd_data_out  <= 16'h0000;
    end else begin
      rd_valid_out <= 1'b0;
      if (state_q == asram_pkg::ASRAM_READ && cnt_done) begin
        rd_valid_out <= 1'b1;
        rd_data_out  <= {req_q.lane_n[1] ? 8'h00 : dq_s2_q[15:8],
                         req_q.lane_n[0] ? 8'h00 : dq_s2_q[7:0]};
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  a_write_strobe_read: assert property (@(posedge core_clk_in)
    disable iff (srst_in) !mem_oe_n_out |-> mem_we_n_out)
    else $error("write strobe low during read");
  a_no_drive_oe: assert property (@(posedge core_clk_in)
    disable iff (srst_in) (mem_dq_oe_out != 16'h0000) |-> mem_oe_n_out)
    else $error("host drives data while output enabled");
  a_write_len_min: assert property (@(posedge core_clk_in)
    disable iff (srst_in) $fell(mem_we_n_out) |->
      (!mem_we_n_out && !select_low_active_out)[*1] ##1
      (mem_we_n_out && select_low_active_out))
    else $error("write too short");
  a_addr_stable_wr: assert property (@(posedge core_clk_in)
    disable iff (srst_in) ($rose(mem_we_n_out) && !$past(srst_in)) |->
      $stable(mem_addr_out))
    else $error("address moved during write");
  a_data_before_end: assert property (@(posedge core_clk_in)
    disable iff (srst_in) ($rose(mem_we_n_out) && !$past(srst_in)) |->
      $stable(mem_dq_out) && $stable(mem_dq_oe_out))
    else $error("write data not held to end");
  a_write_lane_data: assert property (@(posedge core_clk_in)
    disable iff (srst_in) !mem_we_n_out |->
      mem_dq_oe_out == {{8{!upper_lane_enable_n_out}},
                        {8{!lower_lane_enable_n_out}}})
    else $error("write data lanes differ from enables");
  a_write_selected: assert property (@(posedge core_clk_in)
    disable iff (srst_in) !mem_we_n_out |->
      !select_low_active_out && select_high_active_out)
    else $error("write strobe without selects");
  a_read_len_min: assert property (@(posedge core_clk_in)
    disable iff (srst_in) $fell(mem_oe_n_out) |->
      !mem_oe_n_out [*3])
    else $error("read cycle too short");
  a_read_addr_hold: assert property (@(posedge core_clk_in)
    disable iff (srst_in) (!mem_oe_n_out && !$past(mem_oe_n_out)) |->
      $stable(mem_addr_out))
    else $error("address moved during read");
  a_addr_before_sel: assert property (@(posedge core_clk_in)
    disable iff (srst_in) $fell(select_low_active_out) |->
      mem_addr_out == req_q.addr)
    else $error("address after select");
  a_release_gap: assert property (@(posedge core_clk_in)
    disable iff (srst_in)
      ($rose(select_low_active_out) && !$past(srst_in)) |->
      !req_ready_out)
    else $error("no bus release gap");
  c_read: cover property (@(posedge core_clk_in) rd_valid_out);
  c_write: cover property (@(posedge core_clk_in) $rose(mem_we_n_out));
  c_lane: cover property (@(posedge core_clk_in)
    !mem_we_n_out && upper_lane_enable_n_out);
  c_upper_read: cover property (@(posedge core_clk_in)
    rd_valid_out && req_q.lane_n == 2'h1);

endmodule : asram_ctrl

// >>> dv/asram_mem_model.sv
`timescale 1ns/100ps
module asram_mem_model (
  // memory pins
  input  wire logic [19:0] addr_in,
  input  wire logic        sel_lo_in,
  input  wire logic        sel_hi_in,
  input  wire logic        we_n_in,
  input  wire logic        oe_n_in,
  input  wire logic [1:0]  lane_n_in,
  input  wire logic [15:0] host_dq_in,
  input  wire logic [15:0] host_oe_in,
  // resolved bus
  output logic [15:0]      dq_out,
  output logic             clash_out
);
  // ****
  // storage and bus
  // ****
  logic [15:0] mem [0:1048575];
  logic [19:0] addr_d;
  logic [1:0]  lane_d;
  logic [15:0] dq_d, word, rdata, en_a, en_b, en_c, drv;
  logic        sel, wr, wr_d, rd;
  initial for (int i = 0; i < 1048576; i++) mem[i] = ~i[15:0];
  assign sel = !sel_lo_in && sel_hi_in && lane_n_in != 2'h3;
  assign wr = sel && !we_n_in;
  assign rd = sel && we_n_in && !oe_n_in;
  assign #1 addr_d = addr_in;
  assign #1 lane_d = lane_n_in;
  assign #1 dq_d = dq_out;
  assign #1 wr_d = wr;
  // store on the edge that ends the write
  always @(negedge wr) begin
    if (wr_d === 1'b1) begin
      word = mem[addr_d];
      if (!lane_d[0]) word[7:0] = dq_d[7:0];
      if (!lane_d[1]) word[15:8] = dq_d[15:8];
      mem[addr_d] = word;
    end
  end
  assign #30 rdata = mem[addr_in];
  assign en_a = {{8{rd && !lane_n_in[1]}}, {8{rd && !lane_n_in[0]}}};
  assign #12 en_b = en_a;
  assign #8 en_c = en_a;
  // drive late, release early
  assign drv = en_b & en_c;
  assign dq_out = host_oe_in & host_dq_in
    | ~host_oe_in & (drv & rdata | ~drv & ~rdata);
  assign clash_out = |(host_oe_in & drv);
endmodule : asram_mem_model

// >>> dv/tb_asram_ctrl.sv
`timescale 1ns/100ps
module tb_asram_ctrl;
  // ****
  // bench
  // ****
  logic        core_clk_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        req_valid_in = 1'b0;
  asram_pkg::asram_req_type req_in = '0;
  logic        req_ready_out, rd_valid_out, sel_lo, sel_hi, we_n, oe_n;
  logic        clash;
  logic [1:0]  lane_n;
  logic [15:0] rd_data_out, dq_in, dq_out, dq_oe, r;
  logic [19:0] addr;
  logic [15:0] shadow [logic [19:0]];
  logic [15:0] expq [$];
  logic [31:0] seed = 32'h49fa;
  int          n_errors = 0;
  int          checks = 0;
  always #50 core_clk_in = ~core_clk_in;
  asram_ctrl asram_ctrl_i (.core_clk_in(core_clk_in), .srst_in(srst_in),
    .req_valid_in(req_valid_in), .req_in(req_in),
    .req_ready_out(req_ready_out), .rd_valid_out(rd_valid_out),
    .rd_data_out(rd_data_out), .mem_addr_out(addr),
    .select_low_active_out(sel_lo), .select_high_active_out(sel_hi),
    .mem_we_n_out(we_n), .mem_oe_n_out(oe_n),
    .upper_lane_enable_n_out(lane_n[1]),
    .lower_lane_enable_n_out(lane_n[0]), .mem_dq_in(dq_in),
    .mem_dq_out(dq_out), .mem_dq_oe_out(dq_oe));
  asram_mem_model asram_mem_model_i (.addr_in(addr), .sel_lo_in(sel_lo),
    .sel_hi_in(sel_hi), .we_n_in(we_n), .oe_n_in(oe_n),
    .lane_n_in(lane_n), .host_dq_in(dq_out), .host_oe_in(dq_oe),
    .dq_out(dq_in), .clash_out(clash));
  task automatic results();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic acc(input logic w, input logic [1:0] l,
                     input logic [19:0] a, input logic [15:0] d);
    int i;
    logic [15:0] o;
    for (i = 0; i < 50 && req_ready_out !== 1'b1; i++) @(negedge core_clk_in);
    if (i == 50) begin
      n_errors++;
      $display("[ERR] %0t ready timeout", $time);
      results();
    end
    req_valid_in = 1'b1;
    req_in = '{w, l, a, d};
    o = shadow.exists(a) ? shadow[a] : ~a[15:0];
    if (!w) expq.push_back(o & {{8{!l[1]}}, {8{!l[0]}}});
    if (w && !l[0]) o[7:0] = d[7:0];
    if (w && !l[1]) o[15:8] = d[15:8];
    shadow[a] = o;
    @(negedge core_clk_in);
    req_valid_in = 1'b0;
  endtask : acc
  always @(negedge core_clk_in) begin
    if (rd_valid_out === 1'b1)
      cmp(rd_data_out, expq.size() ? expq.pop_front() : 16'hxxxx);
    if (srst_in === 1'b0) begin
      cmp({15'h0, clash}, 16'h0);
      if (oe_n === 1'b0) cmp({15'h0, we_n}, 16'h1);
    end
  end
  initial begin
    repeat (3) @(negedge core_clk_in);
    srst_in = 1'b0;
    cmp({sel_lo, sel_hi, we_n, oe_n, lane_n, 9'h0, |dq_oe}, 16'hbc00);
    acc(1'b1, 2'h0, 20'h00000, 16'h1234);
    acc(1'b1, 2'h0, 20'hfffff, 16'hbeef);
    acc(1'b0, 2'h0, 20'h00000, 16'h0);
    acc(1'b0, 2'h0, 20'hfffff, 16'h0);
    $display("bounds done");
    for (int l = 0; l < 4; l++) begin
      r = 16'(rnd());
      acc(1'b1, l[1:0], 20'h00abc, r);
      acc(1'b0, l[1:0], 20'h00abc, 16'h0);
      acc(1'b0, 2'h0, 20'h00abc, 16'h0);
    end
    $display("lanes done");
    for (int n = 0; n < 40; n++) begin
      seed = rnd();
      acc(seed[31], seed[30:29], {seed[28], 16'h0, seed[2:0]}, seed[15:0]);
    end
    $display("random done");
    acc(1'b0, 2'h0, 20'h00001, 16'h0);
    @(negedge core_clk_in);
    srst_in = 1'b1;
    @(negedge core_clk_in);
    srst_in = 1'b0;
    cmp(16'(expq.size()), 16'h1);
    expq.delete();
    acc(1'b0, 2'h0, 20'h00001, 16'h0);
    for (int i = 0; i < 100 && expq.size() > 0; i++) @(negedge core_clk_in);
    cmp(16'(expq.size()), 16'h0);
    $display("reset done");
    results();
  end
endmodule : tb_asram_ctrl
